// ===== include/pwm_fifo_consts.svh
// Constants for the two-channel pulse and serial output block
`ifndef PWM_FIFO_CONSTS_SVH
`define PWM_FIFO_CONSTS_SVH

`define NUM_CHAN        2
`define APB_AW          8
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define FIFO_LW         5
`define WORD_BITS       32

`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_DMA_CFG     8'h08
`define OFS_RANGE1      8'h10
`define OFS_DATA1       8'h14
`define OFS_FIFO_IN     8'h18
`define OFS_RANGE2      8'h20
`define OFS_DATA2       8'h24

`define CTL_STRIDE      8
`define CTL_ENABLE      0
`define CTL_MODE        1
`define CTL_REPEAT      2
`define CTL_IDLE        3
`define CTL_FIFO_SRC    5
`define CTL_CLEAR_FIFO  6

`define STA_FULL        0
`define STA_EMPTY       1
`define STA_WRITE_ERR   2
`define STA_GAP0        4
`define STA_BUSY0       9
`define STA_LEVEL_LSB   16

`define DMA_ENABLE_BIT  31
`define DMA_URG_MSB     15
`define DMA_URG_LSB     8
`define DMA_REQ_MSB     7
`define DMA_REQ_LSB     0

`define RANGE_RESET     32'h0000_0020
`define DATA_RESET      32'h0000_0000
`define THR_RESET       8'h07
`define ZERO_WORD       32'h0000_0000
`define ONE_WORD        32'h0000_0001

`endif

// ===== include/pwm_fifo_pkg.sv
// Types shared by the output block, its channel engines and its FIFO store
package pwm_fifo_pkg;

    typedef struct packed {
        logic fifoSrc;
        logic idleLevel;
        logic repeatLast;
        logic mode;
        logic enable;
    } chan_cfg_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic [31:0] word;
        logic [31:0] acc;
        logic        active;
        logic        waiting;
        logic        pinOut;
    } engine_state_t;

    typedef struct packed {
        logic [15:0][31:0] cells;
        logic [31:0]       rdData;
    } fifo_mem_state_t;

    typedef struct packed {
        chan_cfg_t [1:0]   cfg;
        logic [1:0][31:0]  range;
        logic [1:0][31:0]  data;
        logic              dmaEnable;
        logic [7:0]        urgentThr;
        logic [7:0]        reqThr;
        logic [3:0]        wrPtr;
        logic [3:0]        rdPtr;
        logic [4:0]        level;
        logic              writeError;
        logic [1:0]        gapSeen;
        logic              turn;
        logic              pending;
        logic              pendCh;
        logic              pendRepeat;
        logic [31:0]       lastWord;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              dmaReq;
        logic              dmaPanic;
    } top_state_t;

endpackage

// ===== core/pwm_fifo_mem.sv
// Word store behind the shared channel FIFO, registered read port
`timescale 1ns/1ps
`include "pwm_fifo_consts.svh"

module pwm_fifo_mem (
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic                wrEn,
    input  wire logic [`FIFO_AW-1:0] wrAddr,
    input  wire logic [31:0]         wrData,
    input  wire logic                rdEn,
    input  wire logic [`FIFO_AW-1:0] rdAddr,
    output logic      [31:0]         rdData
);
    pwm_fifo_pkg::fifo_mem_state_t st_ff;
    pwm_fifo_pkg::fifo_mem_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (wrEn) begin
            nxt_st.cells[wrAddr] = wrData;
        end
        if (rdEn) begin
            nxt_st.rdData = st_ff.cells[rdAddr];
        end
        if (!resetn) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    assign rdData = st_ff.rdData;
endmodule // pwm_fifo_mem

// ===== core/pwm_channel_engine.sv
// One output channel: pulse spreading or MSB-first serialising per period
`timescale 1ns/1ps
`include "pwm_fifo_consts.svh"

module pwm_channel_engine (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire pwm_fifo_pkg::chan_cfg_t  cfg,
    input  wire logic [31:0]              range,
    input  wire logic [31:0]              dataWord,
    input  wire logic                     fifoLoad,
    input  wire logic [31:0]              fifoWord,
    output logic                          needWord,
    output logic                          busy,
    output logic                          pinOut
);
    pwm_fifo_pkg::engine_state_t st_ff;
    pwm_fifo_pkg::engine_state_t nxt_st;
    logic [32:0] sum;
    logic        bitVal;
    logic [4:0]  bitIdx;

    always_comb begin
        nxt_st = st_ff;
        sum    = {1'b0, st_ff.acc} + {1'b0, st_ff.word};
        bitVal = cfg.idleLevel;
        bitIdx = 5'(`WORD_BITS - 1) - st_ff.cnt[4:0];
        if (!cfg.enable || range == `ZERO_WORD) begin
            nxt_st.active  = 1'b0;
            nxt_st.waiting = 1'b0;
            nxt_st.cnt     = `ZERO_WORD;
            nxt_st.acc     = `ZERO_WORD;
            nxt_st.pinOut  = cfg.idleLevel;
        end else if (!st_ff.active) begin
            // Waiting for a word leaves the line idle, which is the gap
            nxt_st.pinOut = cfg.idleLevel;
            nxt_st.cnt    = `ZERO_WORD;
            nxt_st.acc    = `ZERO_WORD;
            if (cfg.fifoSrc) begin
                nxt_st.waiting = 1'b1;
                if (fifoLoad && st_ff.waiting) begin
                    nxt_st.word    = fifoWord;
                    nxt_st.active  = 1'b1;
                    nxt_st.waiting = 1'b0;
                end
            end else begin
                nxt_st.word   = dataWord;
                nxt_st.active = 1'b1;
            end
        end else begin
            if (cfg.mode) begin
                // Bits beyond the word carry the idle level as padding
                if (st_ff.cnt < `WORD_BITS) begin
                    bitVal = st_ff.word[bitIdx];
                end else begin
                    bitVal = cfg.idleLevel;
                end
            end else begin
                // Accumulator spreads word-count pulses over range cycles
                if (sum >= {1'b0, range}) begin
                    bitVal     = 1'b1;
                    nxt_st.acc = 32'(sum - {1'b0, range});
                end else begin
                    bitVal     = 1'b0;
                    nxt_st.acc = sum[31:0];
                end
            end
            nxt_st.pinOut = bitVal;
            // Period ends after range cycles, so short ranges truncate
            if (st_ff.cnt == range - `ONE_WORD) begin
                nxt_st.cnt = `ZERO_WORD;
                nxt_st.acc = `ZERO_WORD;
                if (cfg.fifoSrc) begin
                    nxt_st.active  = 1'b0;
                    nxt_st.waiting = 1'b1;
                end else begin
                    nxt_st.word = dataWord;
                end
            end else begin
                nxt_st.cnt = st_ff.cnt + `ONE_WORD;
            end
        end
        if (!resetn) begin
            nxt_st        = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    assign needWord = st_ff.waiting;
    assign busy     = st_ff.active;
    assign pinOut   = st_ff.pinOut;
endmodule // pwm_channel_engine

// ===== core/pwm_channel_data_fifo.sv
// Two-channel pulse/serial output block with shared FIFO and APB registers
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_fifo_consts.svh"

module pwm_channel_data_fifo (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [`APB_AW-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [`NUM_CHAN-1:0]    chanOut,
    output logic                    dmaRequest,
    output logic                    dmaPanic
);
    pwm_fifo_pkg::top_state_t st_ff;
    pwm_fifo_pkg::top_state_t nxt_st;

    logic [`NUM_CHAN-1:0] needWord;
    logic [`NUM_CHAN-1:0] busy;
    logic [`NUM_CHAN-1:0] fifoLoad;
    logic [31:0]          fifoWord;
    logic [31:0]          memRdData;
    logic                 memWrEn;
    logic                 memRdEn;

    // Engine and bus-side combinational terms
    logic                 fifoFull;
    logic                 fifoEmpty;
    logic                 accessDone;
    logic                 accessStart;
    logic                 wrHit;
    logic                 doPush;
    logic                 doPop;
    logic                 doClear;
    logic [1:0]           sharing;
    logic                 other;
    logic [31:0]          rdMux;
    logic                 unmapped;
    logic [1:0]           gapEvent;

    assign fifoFull    = st_ff.level == 5'(`FIFO_DEPTH);
    assign fifoEmpty   = st_ff.level == 5'd0;
    assign accessStart = psel && penable && !st_ff.pready;
    assign accessDone  = psel && penable && st_ff.pready;
    assign wrHit       = accessDone && pwrite;
    assign fifoWord    = st_ff.pendRepeat ? st_ff.lastWord : memRdData;

    // Only channels one and two are built; others have no address
    genvar c;
    generate
        for (c = 0; c < `NUM_CHAN; c = c + 1) begin : g_chan
            assign fifoLoad[c] = st_ff.pending && (st_ff.pendCh == 1'(c));
            assign sharing[c]  = st_ff.cfg[c].enable && st_ff.cfg[c].fifoSrc;
            assign gapEvent[c] = needWord[c] && sharing[c] && fifoEmpty
                                 && !st_ff.cfg[c].repeatLast;
            pwm_channel_engine u_engine (
                .core_clk (core_clk),
                .resetn   (resetn),
                .cfg      (st_ff.cfg[c]),
                .range    (st_ff.range[c]),
                .dataWord (st_ff.data[c]),
                .fifoLoad (fifoLoad[c]),
                .fifoWord (fifoWord),
                .needWord (needWord[c]),
                .busy     (busy[c]),
                .pinOut   (chanOut[c])
            );
        end
    endgenerate

    // Read mux; the FIFO input reads as zero and never shows contents
    always_comb begin
        rdMux    = `ZERO_WORD;
        unmapped = 1'b0;
        case (paddr)
            `OFS_CTRL: begin
                for (int i = 0; i < `NUM_CHAN; i++) begin
                    rdMux[i*`CTL_STRIDE + `CTL_ENABLE]   = st_ff.cfg[i].enable;
                    rdMux[i*`CTL_STRIDE + `CTL_MODE]     = st_ff.cfg[i].mode;
                    rdMux[i*`CTL_STRIDE + `CTL_REPEAT]   =
                        st_ff.cfg[i].repeatLast;
                    rdMux[i*`CTL_STRIDE + `CTL_IDLE]     =
                        st_ff.cfg[i].idleLevel;
                    rdMux[i*`CTL_STRIDE + `CTL_FIFO_SRC] = st_ff.cfg[i].fifoSrc;
                end
            end
            `OFS_STATUS: begin
                rdMux[`STA_FULL]      = fifoFull;
                rdMux[`STA_EMPTY]     = fifoEmpty;
                rdMux[`STA_WRITE_ERR] = st_ff.writeError;
                rdMux[`STA_GAP0 +: 2] = st_ff.gapSeen;
                rdMux[`STA_BUSY0 +: 2] = busy;
                rdMux[`STA_LEVEL_LSB +: `FIFO_LW] = st_ff.level;
            end
            `OFS_DMA_CFG: begin
                rdMux[`DMA_ENABLE_BIT]             = st_ff.dmaEnable;
                rdMux[`DMA_URG_MSB:`DMA_URG_LSB]   = st_ff.urgentThr;
                rdMux[`DMA_REQ_MSB:`DMA_REQ_LSB]   = st_ff.reqThr;
            end
            `OFS_RANGE1:  rdMux = st_ff.range[0];
            `OFS_DATA1:   rdMux = st_ff.data[0];
            `OFS_FIFO_IN: rdMux = `ZERO_WORD;
            `OFS_RANGE2:  rdMux = st_ff.range[1];
            `OFS_DATA2:   rdMux = st_ff.data[1];
            default:      unmapped = 1'b1;
        endcase
    end

    always_comb begin
        nxt_st  = st_ff;
        doClear = wrHit && (paddr == `OFS_CTRL) && pwdata[`CTL_CLEAR_FIFO];
        // A full FIFO drops the word and leaves stored words intact
        doPush  = wrHit && (paddr == `OFS_FIFO_IN) && !fifoFull;
        doPop   = 1'b0;
        other   = !st_ff.turn;

        // APB: prepare answer on first access edge, commit on second
        // Error flag stands only in the cycle that pready does
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (accessStart) begin
            nxt_st.pready  = 1'b1;
            nxt_st.prdata  = pwrite ? `ZERO_WORD : rdMux;
            nxt_st.pslverr = unmapped;
        end

        if (wrHit) begin
            case (paddr)
                `OFS_CTRL: begin
                    for (int i = 0; i < `NUM_CHAN; i++) begin
                        nxt_st.cfg[i].enable     =
                            pwdata[i*`CTL_STRIDE + `CTL_ENABLE];
                        nxt_st.cfg[i].mode       =
                            pwdata[i*`CTL_STRIDE + `CTL_MODE];
                        nxt_st.cfg[i].repeatLast =
                            pwdata[i*`CTL_STRIDE + `CTL_REPEAT];
                        nxt_st.cfg[i].idleLevel  =
                            pwdata[i*`CTL_STRIDE + `CTL_IDLE];
                        nxt_st.cfg[i].fifoSrc    =
                            pwdata[i*`CTL_STRIDE + `CTL_FIFO_SRC];
                    end
                end
                `OFS_DMA_CFG: begin
                    nxt_st.dmaEnable = pwdata[`DMA_ENABLE_BIT];
                    nxt_st.urgentThr = pwdata[`DMA_URG_MSB:`DMA_URG_LSB];
                    nxt_st.reqThr    = pwdata[`DMA_REQ_MSB:`DMA_REQ_LSB];
                end
                `OFS_RANGE1: nxt_st.range[0] = pwdata;
                `OFS_DATA1:  nxt_st.data[0]  = pwdata;
                `OFS_RANGE2: nxt_st.range[1] = pwdata;
                `OFS_DATA2:  nxt_st.data[1]  = pwdata;
                default: begin
                end
            endcase
        end

        // Sticky flags: a new event in the clearing cycle still sets
        if (wrHit && (paddr == `OFS_STATUS)) begin
            if (pwdata[`STA_WRITE_ERR]) begin
                nxt_st.writeError = 1'b0;
            end
            nxt_st.gapSeen = st_ff.gapSeen & ~pwdata[`STA_GAP0 +: 2];
        end
        if (wrHit && (paddr == `OFS_FIFO_IN) && fifoFull) begin
            nxt_st.writeError = 1'b1;
        end
        nxt_st.gapSeen = nxt_st.gapSeen | gapEvent;

        // Turn skips channels that are not sharing the FIFO
        nxt_st.pending = 1'b0;
        if (!sharing[st_ff.turn] && sharing[other]) begin
            nxt_st.turn = other;
        end else if (!st_ff.pending && needWord[st_ff.turn]) begin
            // One grant at a time keeps the sharers in lock-step
            if (!fifoEmpty) begin
                doPop             = 1'b1;
                nxt_st.pending    = 1'b1;
                nxt_st.pendCh     = st_ff.turn;
                nxt_st.pendRepeat = 1'b0;
                if (sharing[other]) begin
                    nxt_st.turn = other;
                end
            end else if (st_ff.cfg[st_ff.turn].repeatLast) begin
                nxt_st.pending    = 1'b1;
                nxt_st.pendCh     = st_ff.turn;
                nxt_st.pendRepeat = 1'b1;
            end
        end
        if (st_ff.pending && !st_ff.pendRepeat) begin
            nxt_st.lastWord = memRdData;
        end

        // Pointers and fill level; clearing wins over push and pop
        if (doPush) begin
            nxt_st.wrPtr = st_ff.wrPtr + 4'd1;
        end
        if (doPop) begin
            nxt_st.rdPtr = st_ff.rdPtr + 4'd1;
        end
        nxt_st.level = st_ff.level + 5'(doPush) - 5'(doPop);
        if (doClear) begin
            nxt_st.wrPtr   = 4'd0;
            nxt_st.rdPtr   = 4'd0;
            nxt_st.level   = 5'd0;
            nxt_st.pending = 1'b0;
        end

        // Requests compare the fill level seen this cycle
        nxt_st.dmaReq   = st_ff.dmaEnable
                          && ({3'd0, st_ff.level} <= st_ff.reqThr);
        nxt_st.dmaPanic = st_ff.dmaEnable
                          && ({3'd0, st_ff.level} <= st_ff.urgentThr);

        if (!resetn) begin
            nxt_st           = '0;
            nxt_st.range[0]  = `RANGE_RESET;
            nxt_st.range[1]  = `RANGE_RESET;
            nxt_st.data[0]   = `DATA_RESET;
            nxt_st.data[1]   = `DATA_RESET;
            nxt_st.dmaEnable = 1'b0;
            nxt_st.urgentThr = `THR_RESET;
            nxt_st.reqThr    = `THR_RESET;
        end
    end

    assign memWrEn = doPush && resetn;
    assign memRdEn = doPop;

    pwm_fifo_mem u_mem (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wrEn     (memWrEn),
        .wrAddr   (st_ff.wrPtr),
        .wrData   (pwdata),
        .rdEn     (memRdEn),
        .rdAddr   (st_ff.rdPtr),
        .rdData   (memRdData)
    );

    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    assign prdata     = st_ff.prdata;
    assign pready     = st_ff.pready;
    assign pslverr    = st_ff.pslverr;
    assign dmaRequest = st_ff.dmaReq;
    assign dmaPanic   = st_ff.dmaPanic;
endmodule // pwm_channel_data_fifo

// ===== testbench/pwm_fifo_checker.sv
// Port assertions for the shared FIFO output block
`timescale 1ns/1ps
`include "pwm_fifo_consts.svh"
module pwm_fifo_checker (
    input wire logic                core_clk,
    input wire logic                resetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [`APB_AW-1:0]  paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [`NUM_CHAN-1:0] chanOut,
    input wire logic                dmaRequest,
    input wire logic                dmaPanic
);
    logic [31:0] ctrlCopy_ff;
    logic [31:0] dmaCopy_ff;
    logic        commit;
    logic        mapped;
    assign commit = psel && penable && pready && pwrite;
    assign mapped = paddr inside {`OFS_CTRL, `OFS_STATUS, `OFS_DMA_CFG,
        `OFS_RANGE1, `OFS_DATA1, `OFS_FIFO_IN, `OFS_RANGE2, `OFS_DATA2};
    // Software view of the config, so outputs can be tied to it
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrlCopy_ff <= 32'h0000_0000;
            dmaCopy_ff  <= 32'h0000_0707;
        end else if (commit && paddr == `OFS_CTRL) begin
            ctrlCopy_ff <= pwdata;
        end else if (commit && paddr == `OFS_DMA_CFG) begin
            dmaCopy_ff <= pwdata;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        !pready ##1 pready ##1 !pready;
    endsequence
    property p_reset_quiet;
        @(posedge core_clk) !resetn |=> !pready && !dmaRequest && !dmaPanic;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    property p_req_off;
        @(posedge core_clk) disable iff (!resetn)
        !dmaCopy_ff[31] && !$past(dmaCopy_ff[31]) |-> !dmaRequest && !dmaPanic;
    endproperty
    a_req_off: assert property (p_req_off)
        else $error("dma request while disabled");
    // Both flags come from one fill level, so a lower urgent
    // threshold can never raise urgent_threshold alone
    property p_urgent_threshold_order;
        @(posedge core_clk) disable iff (!resetn)
        dmaCopy_ff[15:8] <= dmaCopy_ff[7:0] && $stable(dmaCopy_ff)
        && dmaCopy_ff == $past(dmaCopy_ff, 2) |-> !(dmaPanic && !dmaRequest);
    endproperty
    a_urgent_threshold_order: assert property (p_urgent_threshold_order)
        else $error("urgent_threshold without request");
    property p_fifo_read_zero;
        @(posedge core_clk) disable iff (!resetn)
        pready && !pwrite && paddr == `OFS_FIFO_IN |-> prdata == 0 && !pslverr;
    endproperty
    a_fifo_read_zero: assert property (p_fifo_read_zero)
        else $error("fifo input read not zero");
    property p_unmapped_err;
        @(posedge core_clk) disable iff (!resetn)
        pready && !mapped |-> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");
    property p_err_scope;
        @(posedge core_clk) disable iff (!resetn)
        pslverr |-> pready && !mapped;
    endproperty
    a_err_scope: assert property (p_err_scope)
        else $error("error on mapped access");
    property p_one_wait;
        @(posedge core_clk) disable iff (!resetn)
        s_setup ##1 (psel && penable) |-> s_access;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer timing wrong");
    property p_idle_ch1;
        @(posedge core_clk) disable iff (!resetn)
        !ctrlCopy_ff[0] && $stable(ctrlCopy_ff)
        && ctrlCopy_ff == $past(ctrlCopy_ff, 3) |-> chanOut[0] == ctrlCopy_ff[3];
    endproperty
    a_idle_ch1: assert property (p_idle_ch1)
        else $error("channel one not idle");
    property p_idle_ch2;
        @(posedge core_clk) disable iff (!resetn)
        !ctrlCopy_ff[8] && $stable(ctrlCopy_ff)
        && ctrlCopy_ff == $past(ctrlCopy_ff, 3) |-> chanOut[1] == ctrlCopy_ff[11];
    endproperty
    a_idle_ch2: assert property (p_idle_ch2)
        else $error("channel two not idle");
endmodule // pwm_fifo_checker

// ===== testbench/apb_host_model.sv
// Processor and DMA side: APB master issuing register transfers
`timescale 1ns/1ps
module apb_host_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // Ready and read data are taken at the rising edge that commits
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // apb_host_model

// ===== testbench/pwm_channel_data_fifo_test.sv
// Self-checking bench for the shared FIFO output block
`timescale 1ns/1ps
`include "pwm_fifo_consts.svh"
module pwm_channel_data_fifo_test;
    logic        core_clk;
    logic        resetn;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  chanOut;
    logic        dmaRequest, dmaPanic, err;
    logic [63:0] bits;
    int          nMismatch = 0;
    int          checkCount = 0;
    int          n1, n2;
    pwm_channel_data_fifo pwm_channel_data_fifo_inst (.core_clk, .resetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .chanOut, .dmaRequest, .dmaPanic);
    apb_host_model apb_host_model_inst (.core_clk, .prdata, .pready,
        .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task check(input string what, input logic [63:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb_host_model_inst.xfer(1'b1, a, d, rd, err);
    endtask
    task rdck(input logic [7:0] a, input logic [32:0] exp);
        apb_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rd, err);
        check($sformatf("reg %h", a), {err, rd}, exp);
    endtask
    task waitOut(input int ch, input logic lvl);
        for (int i = 0; i < 80 && chanOut[ch] !== lvl; i++) @(negedge core_clk);
    endtask
    task grab(input int ch, input int n);
        bits = 0;
        for (int i = 0; i < n; i++) begin
            bits = {bits[62:0], chanOut[ch]};
            @(negedge core_clk);
        end
    endtask
    task testRegs;
        rdck(`OFS_DMA_CFG, 33'h0_0000_0707);
        rdck(`OFS_RANGE1, 33'h0_0000_0020);
        rdck(`OFS_RANGE2, 33'h0_0000_0020);
        rdck(`OFS_DATA1, 33'h0_0000_0000);
        rdck(`OFS_DATA2, 33'h0_0000_0000);
        wr(`OFS_FIFO_IN, 32'h1234_5678);
        rdck(`OFS_FIFO_IN, 33'h0_0000_0000);
        wr(8'h30, 32'h0000_0005);
        rdck(8'h30, 33'h1_0000_0000);
        rdck(`OFS_RANGE1, 33'h0_0000_0020);
        wr(`OFS_CTRL, 32'h0000_0040);
        $display("registers done");
    endtask
    task testDma;
        check("request off", {dmaRequest, dmaPanic}, 2'b00);
        wr(`OFS_DMA_CFG, 32'h8000_0102);
        repeat (3) @(negedge core_clk);
        check("empty flags", {dmaRequest, dmaPanic}, 2'b11);
        for (int i = 0; i < 17; i++) begin
            wr(`OFS_FIFO_IN, 32'hA000_0000 + i);
            if (i == 1 || i == 2) begin
                repeat (3) @(negedge core_clk);
                check("level flags", {dmaRequest, dmaPanic}, {i == 1, 1'b0});
            end
        end
        rdck(`OFS_STATUS, 33'h0_0010_0005);
        wr(`OFS_CTRL, 32'h0000_0040);
        wr(`OFS_STATUS, 32'h0000_0004);
        wr(`OFS_DMA_CFG, 32'h0000_0707);
        rdck(`OFS_STATUS, 33'h0_0000_0002);
        $display("dma thresholds done");
    endtask
    task testSerial;
        wr(`OFS_RANGE1, 32'h0000_0008);
        wr(`OFS_DATA1, 32'hA5FF_FFFF);
        wr(`OFS_CTRL, 32'h0000_0003);
        waitOut(0, 1'b1);
        grab(0, 16);
        check("short serial", bits, 64'h0000_0000_0000_A5A5);
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_RANGE2, 32'h0000_0024);
        wr(`OFS_DATA2, 32'h8000_0001);
        wr(`OFS_CTRL, 32'h0000_0B00);
        waitOut(1, 1'b1);
        waitOut(1, 1'b0);
        grab(1, 37);
        check("padded serial", bits, 64'h0000_0000_0000_007E);
        wr(`OFS_CTRL, 32'h0000_0000);
        $display("serial done");
    endtask
    task testPwm;
        wr(`OFS_RANGE1, 32'h0000_0008);
        wr(`OFS_DATA1, 32'h0000_0003);
        wr(`OFS_CTRL, 32'h0000_0001);
        repeat (10) @(negedge core_clk);
        n1 = 0;
        repeat (80) begin
            n1 += chanOut[0];
            @(negedge core_clk);
        end
        check("pulse count", n1, 30);
        wr(`OFS_CTRL, 32'h0000_0000);
        $display("pulse done");
    endtask
    task testShare;
        wr(`OFS_CTRL, 32'h0000_0040);
        wr(`OFS_RANGE1, 32'h0000_0020);
        wr(`OFS_RANGE2, 32'h0000_0020);
        wr(`OFS_FIFO_IN, 32'hFF00_0000);
        wr(`OFS_FIFO_IN, 32'hFFFF_FF00);
        wr(`OFS_CTRL, 32'h0000_2323);
        n1 = 0;
        n2 = 0;
        repeat (300) begin
            n1 += chanOut[0];
            n2 += chanOut[1];
            @(negedge core_clk);
        end
        check("first word ch1", n1, 8);
        check("second word ch2", n2, 24);
        apb_host_model_inst.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
        check("gaps and empty", rd & 32'h0000_0637, 32'h0000_0032);
        // Alone on the FIFO with repeat set, the last popped word recurs
        wr(`OFS_CTRL, 32'h0000_0027);
        repeat (10) @(negedge core_clk);
        n1 = 0;
        repeat (68) begin
            n1 += chanOut[0];
            @(negedge core_clk);
        end
        check("repeat last", n1, 48);
        wr(`OFS_CTRL, 32'h0000_0040);
        $display("sharing done");
    endtask
    task completeRun;
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        testRegs();
        testDma();
        testSerial();
        testPwm();
        testShare();
        completeRun();
    end
    // Whole run needs about eight hundred cycles
    initial begin
        #200000;
        nMismatch++;
        completeRun();
    end
endmodule // pwm_channel_data_fifo_test
bind pwm_channel_data_fifo pwm_fifo_checker pwm_fifo_checker_inst (
    .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chanOut, .dmaRequest, .dmaPanic);
